// *** pkg/ksd_pkg.sv ***
`default_nettype none
package ksd_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_DISPLAY_TEST    = 8'h07;
  localparam logic [7:0] ADDR_SWITCH_DEBOUNCE = 8'h08;
  localparam logic [7:0] ADDR_SWITCH_CLOSED   = 8'h0C;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int         TEST_ENABLE_BIT      = 0;
  localparam logic [7:0] RST_DISPLAY_TEST     = 8'h00;
  localparam logic [7:0] RST_SWITCH_STATUS    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

  // ------------------------------------------------------------------
  // Display drive figures
  // ------------------------------------------------------------------
  localparam logic [5:0] TEST_DUTY_STEPS      = 6'h1C;
  localparam logic [5:0] PWM_STEP_RESET       = 6'h00;

  // Register access request from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ksd_req_t;

  // Per-scan results from the keyscan engine
  typedef struct packed {
    logic       scan_done;
    logic [7:0] closed;
    logic [7:0] debounced;
  } ksd_scan_t;

  // Display drive request toward the LED drivers
  typedef struct packed {
    logic       all_on;
    logic [5:0] duty;
  } ksd_drive_t;

endpackage
`default_nettype wire

// *** rtl/ksd_test_pwm.sv ***
`timescale 1ns/1ps
`default_nettype none
module ksd_test_pwm #(
  parameter int STEP_W = 6
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [STEP_W-1:0] duty,
  output logic                   pwm_on
);

  // ------------------------------------------------------------------
  // Free running step counter, one of 64 steps per clock
  // ------------------------------------------------------------------
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] next_step;
  logic              next_pwm_on;

  always_comb begin
    next_step   = step + {{(STEP_W-1){1'b0}}, 1'b1};
    next_pwm_on = (step < duty);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      step   <= ksd_pkg::PWM_STEP_RESET;
      pwm_on <= 1'b0;
    end else begin
      step   <= next_step;
      pwm_on <= next_pwm_on;
    end
  end

endmodule
`default_nettype wire

// *** rtl/ksd_key_status_display_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Closed bit follows latest scan result
// - Closed-status read changes nothing
// - Writes to 0x0C are discarded
// - Test lights all LEDs, settings untouched
// - Test drive duty fixed at 28/64
// - Register 0x07 bit D0 selects test
// - Debounced register: switch n in Dn
// - Closed register: switch n in Dn
// - Debounced bits accumulate until read
// - Debounced read clears after data returned
// - Debounced read drops key interrupt
// - Writes to 0x08 are ignored
module ksd_key_status_display_test #(
  parameter int NUM_SWITCHES = 8,
  parameter int STEP_W       = 6
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire ksd_pkg::ksd_req_t    req,
  input  wire ksd_pkg::ksd_scan_t   scan,
  input  wire logic [STEP_W-1:0]    normal_duty,
  input  wire logic                 normal_shutdown,
  output logic [7:0]                rdata,
  output logic                      rvalid,
  output logic                      key_irq,
  output ksd_pkg::ksd_drive_t       drive,
  output logic                      test_mode,
  output logic                      test_pwm_on
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]              test_reg;
  logic [NUM_SWITCHES-1:0] closed_reg;
  logic [NUM_SWITCHES-1:0] debounced_reg;
  logic [7:0]              next_test_reg;
  logic [NUM_SWITCHES-1:0] next_closed_reg;
  logic [NUM_SWITCHES-1:0] next_debounced_reg;
  logic [7:0]              next_rdata;
  logic                    next_rvalid;
  logic                    next_key_irq;
  ksd_pkg::ksd_drive_t     next_drive;
  logic                    next_test_mode;
  logic                    rd_debounced;

  // ------------------------------------------------------------------
  // Per-switch status bits; switch n lives in bit n
  // ------------------------------------------------------------------
  generate
    for (genvar n = 0; n < NUM_SWITCHES; n++) begin : g_sw
      always_comb begin
        // Scan result replaces the pressed bit each pass
        next_closed_reg[n] = scan.scan_done ? scan.closed[n] : closed_reg[n];
        // Set wins over the read clear so no press is lost
        if (scan.scan_done && scan.debounced[n]) begin
          next_debounced_reg[n] = 1'b1;
        end else if (rd_debounced) begin
          next_debounced_reg[n] = 1'b0;
        end else begin
          next_debounced_reg[n] = debounced_reg[n];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------------
  always_comb begin
    rd_debounced  = req.rd && hit(req.addr, ksd_pkg::ADDR_SWITCH_DEBOUNCE);
    next_test_reg = test_reg;
    // Only the test register accepts writes; 0x08 and 0x0C drop them
    if (req.wr && hit(req.addr, ksd_pkg::ADDR_DISPLAY_TEST)) begin
      next_test_reg = req.wdata;
    end
    next_rvalid = req.rd;
    next_rdata  = ksd_pkg::UNMAPPED_READ_VALUE;
    if (req.rd) begin
      unique case (1'b1)
        hit(req.addr, ksd_pkg::ADDR_DISPLAY_TEST): begin
          next_rdata = test_reg;
        end
        hit(req.addr, ksd_pkg::ADDR_SWITCH_DEBOUNCE): begin
          // Data captured from pre-clear value
          next_rdata = 8'(debounced_reg);
        end
        hit(req.addr, ksd_pkg::ADDR_SWITCH_CLOSED): begin
          // Pure read, no state touched
          next_rdata = 8'(closed_reg);
        end
        default: begin
          next_rdata = ksd_pkg::UNMAPPED_READ_VALUE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and display override
  // ------------------------------------------------------------------
  always_comb begin
    // Interrupt mirrors pending debounced keys, so the read clears it
    next_key_irq   = |next_debounced_reg;
    next_test_mode = test_reg[ksd_pkg::TEST_ENABLE_BIT];
    // Override is on the drive path only; digit planes stay per die
    if (next_test_mode) begin
      next_drive.all_on = 1'b1;
      next_drive.duty   = ksd_pkg::TEST_DUTY_STEPS;
    end else begin
      next_drive.all_on = 1'b0;
      next_drive.duty   = normal_shutdown ? '0 : normal_duty;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      test_reg      <= ksd_pkg::RST_DISPLAY_TEST;
      closed_reg    <= '0;
      debounced_reg <= '0;
      rdata         <= ksd_pkg::RST_SWITCH_STATUS;
      rvalid        <= 1'b0;
      key_irq       <= 1'b0;
      drive         <= '0;
      test_mode     <= 1'b0;
    end else begin
      test_reg      <= next_test_reg;
      closed_reg    <= next_closed_reg;
      debounced_reg <= next_debounced_reg;
      rdata         <= next_rdata;
      rvalid        <= next_rvalid;
      key_irq       <= next_key_irq;
      drive         <= next_drive;
      test_mode     <= next_test_mode;
    end
  end

  // ------------------------------------------------------------------
  // Fixed test duty generator
  // ------------------------------------------------------------------
  ksd_test_pwm #(
    .STEP_W (STEP_W)
  ) u_pwm (
    .core_clk (core_clk),
    .rstn     (rstn),
    .duty     (ksd_pkg::TEST_DUTY_STEPS),
    .pwm_on   (test_pwm_on)
  );

endmodule
`default_nettype wire

// *** sim/ksd_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ksd_properties (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire ksd_pkg::ksd_req_t   req,
  input wire ksd_pkg::ksd_scan_t  scan,
  input wire logic [5:0]          normal_duty,
  input wire logic                normal_shutdown,
  input wire logic [7:0]          rdata,
  input wire logic                rvalid,
  input wire logic                key_irq,
  input wire ksd_pkg::ksd_drive_t drive,
  input wire logic                test_mode,
  input wire logic                test_pwm_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rd_answer_a:
    assert property (rvalid == $past(req.rd)) else $error("rvalid out of step");
  closed_read_a:
    assert property (scan.scan_done ##1 !scan.scan_done [*2] ##1 (req.rd && req.addr == 8'h0C)
      |=> rdata == $past(scan.closed, 4)) else $error("closed status wrong");
  irq_set_a:
    assert property (scan.scan_done && |scan.debounced |-> ##[1:3] key_irq)
      else $error("key interrupt missing");
  irq_clear_a:
    assert property (req.rd && req.addr == 8'h08 && !scan.scan_done && !$past(scan.scan_done)
      |-> ##2 !key_irq) else $error("key interrupt not cleared");
  test_select_a:
    assert property ((req.wr && req.addr == 8'h07) ##1 !(req.wr && req.addr == 8'h07)
      |=> test_mode == $past(req.wdata[0], 2)) else $error("test select wrong");
  test_all_on_a:
    assert property (drive.all_on == test_mode) else $error("all-on drive wrong");
  test_duty_a:
    assert property (test_mode |-> drive.duty == ksd_pkg::TEST_DUTY_STEPS)
      else $error("test duty wrong");
  normal_duty_a:
    assert property (!test_mode |->
      drive.duty == ($past(normal_shutdown) ? 6'h00 : $past(normal_duty)))
      else $error("normal duty wrong");
  pwm_low_a:
    assert property ($fell(test_pwm_on) |-> ##35 !test_pwm_on ##1 test_pwm_on)
      else $error("test pwm low time wrong");
  pwm_high_a:
    assert property ($rose(test_pwm_on) |-> ##27 test_pwm_on ##1 !test_pwm_on)
      else $error("test pwm high time wrong");
endmodule
`default_nettype wire

// *** sim/ksd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ksd_host_model (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire ksd_pkg::ksd_req_t cmd,
  output var ksd_pkg::ksd_req_t  req
);
  // Flopped so each access is a clean one-cycle pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req <= '0;
    end else begin
      req <= cmd;
    end
  end
endmodule
`default_nettype wire

// *** sim/ksd_key_status_display_test_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ksd_key_status_display_test_tb_top;
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  ksd_pkg::ksd_req_t   cmd      = '0;
  ksd_pkg::ksd_req_t   req;
  ksd_pkg::ksd_scan_t  scan     = '0;
  logic [5:0]          duty     = 6'h00;
  logic                shut     = 1'b0;
  logic [7:0]          rdata;
  logic                rvalid;
  logic                key_irq;
  logic                test_mode;
  logic                test_pwm_on;
  ksd_pkg::ksd_drive_t drive;
  logic [7:0]          exp_q[$];
  logic [31:0]         rnd      = 32'h8337;
  logic [7:0]          d1;
  logic [7:0]          d2;
  logic [7:0]          c;
  int                  fails    = 0;
  int                  n_checks = 0;
  initial forever #12.5 core_clk = ~core_clk;
  ksd_host_model host (.core_clk, .rstn, .cmd, .req);
  ksd_key_status_display_test uut (.core_clk, .rstn, .req, .scan, .normal_duty(duty),
    .normal_shutdown(shut), .rdata, .rvalid, .key_irq, .drive, .test_mode, .test_pwm_on);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random duty and shutdown ride along with every step
  task automatic step(input ksd_pkg::ksd_req_t q, input ksd_pkg::ksd_scan_t s,
                      input logic [7:0] e);
    @(posedge core_clk);
    cmd  <= q;
    scan <= s;
    duty <= rnd[5:0];
    shut <= rnd[6];
    rnd = lfsr(rnd);
    if (q.rd) exp_q.push_back(e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    step({1'b0, 1'b1, a, 8'h00}, '0, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step({1'b1, 1'b0, a, d}, '0, 8'h00);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) cmp8(rdata, exp_q.pop_front());
      else cmp8(rdata, (rdata === 8'h00) ? 8'hFF : 8'h00);
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h07, 8'h00);
    rd(8'h3A, 8'h00);
    wr(8'h07, 8'hFE);
    rd(8'h07, 8'hFE);
    repeat (4) begin
      d1 = rnd[7:0];
      d2 = rnd[15:8];
      c  = rnd[23:16];
      step('0, {1'b1, ~c, d1}, 8'h00);
      step('0, '0, 8'h00);
      step('0, {1'b1, c, d2}, 8'h00);
      step('0, '0, 8'h00);
      rd(8'h0C, c);
      wr(8'h08, 8'hFF);
      wr(8'h0C, ~c);
      rd(8'h0C, c);
      rd(8'h08, d1 | d2);
      rd(8'h08, 8'h00);
      repeat (4) step('0, '0, 8'h00);
    end
    // Debounce landing on the clearing read must survive it
    d1 = rnd[7:0];
    rd(8'h08, 8'h00);
    step('0, {1'b1, 8'h00, d1}, 8'h00);
    step('0, '0, 8'h00);
    rd(8'h08, d1);
    // Test mode stays on to the end so test_duty_a sees the fixed duty for the rest of the run
    d1 = rnd[7:0] | 8'h01;
    wr(8'h07, d1);
    rd(8'h07, d1);
    repeat (150) step('0, '0, 8'h00);
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge core_clk);
    if (exp_q.size() > 0) fails++;
    complete_run();
  end
endmodule
bind ksd_key_status_display_test ksd_properties chk (.core_clk, .rstn, .req, .scan,
  .normal_duty, .normal_shutdown, .rdata, .rvalid, .key_irq, .drive, .test_mode,
  .test_pwm_on);
`default_nettype wire
